// [bench/chg_link_sva.sv]
// chg_link_sva: concurrent checks on the pin link between device and host
// assumes one clock domain; instantiated beside chg_if by the bench top
`timescale 1ns/100ps
module chg_link_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic charge_status_a_o,
  input wire logic charge_status_a_oe_n,
  input wire logic charge_status_b_o,
  input wire logic charge_status_b_oe_n,
  input wire logic supply_valid_n_o,
  input wire logic supply_valid_n_oe_n,
  input wire logic usb_current_select_oe_n,
  input wire logic adapter_current_set,
  input wire logic temp_sense_test
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  stat_a_sink_a: assert property (
    !charge_status_a_oe_n |-> !charge_status_a_o) else $error("stat a high");
  stat_b_sink_a: assert property (
    !charge_status_b_oe_n |-> !charge_status_b_o) else $error("stat b high");
  pg_sink_a: assert property (
    !supply_valid_n_oe_n |-> !supply_valid_n_o) else $error("pg sources");
  reset_release_a: assert property (
    $rose(hresetn) |-> charge_status_a_oe_n && charge_status_b_oe_n
      && supply_valid_n_oe_n) else $error("pins driven after reset");
  adp_disable_a: assert property (
    $rose(adapter_current_set) |-> ##[3:6]
      (charge_status_a_oe_n && charge_status_b_oe_n))
    else $error("status kept after disable");
  usb_float_a: assert property (
    $rose(usb_current_select_oe_n) |-> ##[3:6]
      (charge_status_a_oe_n && charge_status_b_oe_n))
    else $error("status kept after usb float");
  test_exit_a: assert property (
    $fell(temp_sense_test) && !charge_status_a_oe_n && !charge_status_b_oe_n
      |-> ##[3:6] charge_status_a_oe_n) else $error("test mode kept");
  stat_steady_a: assert property (
    $changed(charge_status_a_oe_n) |=> $stable(charge_status_a_oe_n))
    else $error("stat a glitch");
endmodule

// [bench/test_charger_state_status_control.sv]
// test_charger_state_status_control: scenario bench for device and host
// assumes both ends meet in chg_if; analog levels come from the bench
`timescale 1ns/100ps
module test_charger_state_status_control;
  localparam int unsigned SAFE = 600;
  localparam int unsigned FILT = 20;
  logic                hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic         [31:0] haddr, hwdata, hrdata, rd;
  logic          [1:0] htrans;
  logic          [2:0] hsize;
  logic                sup_undervoltage_lockout, sup_vreg, sup_bat, bat_in, bat_pre, bat_vreg;
  logic                bat_rech, term_low, t_lo_ok, t_hi_ok;
  logic                pass_on, ldo_mode, cur_high, from_adp, pre_cur;
  logic                bias_on, pull_on, low_power;
  chg_pkg::chg_state_t state;
  int                  err_count, comparisons, n, i;
  logic         [31:0] codes [3];

  assign hready = hreadyout;
  chg_if link ();
  wire           [2:0] pins = {link.pg_pin, link.stat_b_pin, link.stat_a_pin};
  chg_dev #(.SAFETY_CYC(SAFE), .FILT_CYC(FILT)) u_chg_dev (
    .hclk(hclk), .hresetn(hresetn), .link(link),
    .supply_above_undervoltage_lockout(sup_undervoltage_lockout), .supply_above_bat(sup_bat),
    .supply_above_vreg_margin(sup_vreg), .battery_present(bat_in),
    .bat_below_precond(bat_pre), .bat_at_vreg(bat_vreg),
    .bat_below_recharge(bat_rech), .term_current_low(term_low),
    .temp_above_low(t_lo_ok), .temp_below_high(t_hi_ok),
    .pass_on(pass_on), .ldo_mode(ldo_mode), .current_high(cur_high),
    .current_from_adapter(from_adp), .precond_current(pre_cur),
    .thermistor_bias_current(bias_on), .sense_pulldown(pull_on),
    .low_power(low_power), .state(state));
  chg_host u_chg_host (
    .hclk(hclk), .hresetn(hresetn), .link(link), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  chg_link_sva u_chg_link_sva (
    .hclk(hclk), .hresetn(hresetn),
    .charge_status_a_o(link.charge_status_a_o),
    .charge_status_a_oe_n(link.charge_status_a_oe_n),
    .charge_status_b_o(link.charge_status_b_o),
    .charge_status_b_oe_n(link.charge_status_b_oe_n),
    .supply_valid_n_o(link.supply_valid_n_o),
    .supply_valid_n_oe_n(link.supply_valid_n_oe_n),
    .usb_current_select_oe_n(link.usb_current_select_oe_n),
    .adapter_current_set(link.adapter_current_set),
    .temp_sense_test(link.temp_sense_test));

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // address phase held until hready, then data phase until hready again
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 100);
    rd = hrdata;
    chk(hresp === 1'b0, "bus response not okay");
    if (k >= 100) begin
      chk(1'b0, "bus hang");
      wrap_up();
    end
  endtask

  task automatic wait_st(input chg_pkg::chg_state_t s, input int lim);
    n = 0;
    while (state !== s && n < lim) begin
      @(posedge hclk);
      n++;
    end
    chk(state === s, "state not reached");
    if (state !== s) wrap_up();
  endtask

  // pins reach the status register through the host synchroniser: poll
  task automatic wait_stat(input logic [2:0] e);
    int k;
    k = 0;
    rd = {29'h000_0000, ~e};
    while (rd[2:0] !== e && k < 40) begin
      bus(1'b0, chg_pkg::REG_STAT, 32'h0000_0000);
      k++;
    end
    chk(rd[2:0] === e, "status pins");
    if (rd[2:0] !== e) wrap_up();
  endtask

  task automatic t_reset();
    chk(state === chg_pkg::ST_SHUTDOWN, "reset state");
    chk(pins === 3'b111, "reset pins");
    bus(1'b0, chg_pkg::REG_CTRL, 32'h0000_0000);
    chk(rd === 32'h0000_0001, "ctrl reset value");
    bus(1'b1, 8'h08, 32'hffff_ffff);
    bus(1'b0, 8'h08, 32'h0000_0000);
    chk(rd === 32'h0000_0000, "unmapped read");
    wait_stat(3'b011);
    $display("test reset done");
  endtask

  task automatic t_charge();
    bus(1'b1, chg_pkg::REG_CTRL, 32'h0000_0014);
    wait_st(chg_pkg::ST_PRECOND, 20);
    wait_stat(3'b010);
    chk(pre_cur === 1'b1 && cur_high === 1'b1, "usb high");
    chk(bias_on === 1'b1 && pull_on === 1'b0, "bias in charge");
    chk(pass_on === 1'b1 && ldo_mode === 1'b0, "pass off");
    chk(low_power === 1'b0, "still disabled");
    bat_pre <= 1'b0;
    wait_st(chg_pkg::ST_CC, 20);
    bus(1'b1, chg_pkg::REG_CTRL, 32'h0000_0010);
    repeat (4) @(posedge hclk);
    chk(cur_high === 1'b0, "usb low");
    bat_vreg <= 1'b1;
    wait_st(chg_pkg::ST_CV, 20);
    term_low <= 1'b1;
    repeat (FILT / 2) @(posedge hclk);
    term_low <= 1'b0;
    repeat (FILT) @(posedge hclk);
    chk(state === chg_pkg::ST_CV, "short dip ended cycle");
    term_low <= 1'b1;
    wait_st(chg_pkg::ST_DONE, FILT + 40);
    chk(n >= FILT && n <= FILT + 8, "filter length");
    wait_stat(3'b001);
    {term_low, bat_vreg, bat_rech} <= 3'b001;
    wait_stat(3'b010);
    bat_rech <= 1'b0;
    $display("test charge done");
  endtask

  task automatic t_temp_timer();
    bus(1'b1, chg_pkg::REG_CTRL, 32'h0000_0001);
    wait_st(chg_pkg::ST_STANDBY, 20);
    bus(1'b1, chg_pkg::REG_CTRL, 32'h0000_0000);
    wait_st(chg_pkg::ST_CC, 20);
    repeat (100) @(posedge hclk);
    for (i = 0; i < 2; i++) begin
      {t_lo_ok, t_hi_ok} <= (i == 0) ? 2'b10 : 2'b01;
      wait_st(chg_pkg::ST_TEMP_FLT, 8);
      chk(pass_on === 1'b0, "pass on in suspension");
      wait_stat(3'b011);
      repeat (400) @(posedge hclk);
      {t_lo_ok, t_hi_ok} <= 2'b11;
      wait_st(chg_pkg::ST_CC, 8);
    end
    repeat (300) @(posedge hclk);
    chk(state === chg_pkg::ST_CC, "timer ran in suspension");
    wait_st(chg_pkg::ST_TMR_FLT, 300);
    wait_stat(3'b011);
    repeat (50) @(posedge hclk);
    chk(state === chg_pkg::ST_TMR_FLT && pass_on === 1'b0, "fault left");
    bus(1'b1, chg_pkg::REG_CTRL, 32'h0000_0001);
    wait_st(chg_pkg::ST_STANDBY, 20);
    $display("test temperature and timer done");
  endtask

  task automatic t_disable();
    codes = '{32'h0000_0011, 32'h0000_0012, 32'h0000_0018};
    for (i = 0; i < 3; i++) begin
      bus(1'b1, chg_pkg::REG_CTRL, 32'h0000_0010);
      wait_st(chg_pkg::ST_CC, 20);
      wait_stat(3'b010);
      bus(1'b1, chg_pkg::REG_CTRL, codes[i]);
      wait_st(chg_pkg::ST_STANDBY, 8);
      chk(low_power === 1'b1 && pass_on === 1'b0, "not disabled");
      wait_stat(3'b011);
    end
    $display("test disable done");
  endtask

  task automatic t_test_mode();
    bat_in <= 1'b0;
    bus(1'b1, chg_pkg::REG_CTRL, 32'h0000_0020);
    wait_st(chg_pkg::ST_TEST, 20);
    chk(ldo_mode === 1'b1 && from_adp === 1'b1, "regulator mode");
    chk(bias_on === 1'b0 && pull_on === 1'b1, "test bias");
    wait_stat(3'b000);
    bus(1'b1, chg_pkg::REG_CTRL, 32'h0000_0000);
    wait_st(chg_pkg::ST_STANDBY, 20);
    chk(bias_on === 1'b0 && pull_on === 1'b1, "standby bias");
    $display("test system mode done");
  endtask

  task automatic t_supply();
    logic p;
    sup_vreg <= 1'b0;
    // let the drop settle so only probe toggles are counted
    repeat (6) @(posedge hclk);
    n = 0;
    p = link.pg_pin;
    repeat (2200) begin
      @(posedge hclk);
      if (link.pg_pin !== p) n++;
      p = link.pg_pin;
    end
    chk(n >= 2 && n <= 3, "probe pulses");
    {sup_vreg, sup_bat} <= 2'b10;
    wait_st(chg_pkg::ST_SHUTDOWN, 20);
    wait_stat(3'b111);
    chk(bias_on === 1'b0, "bias in shutdown");
    sup_bat <= 1'b1;
    wait_stat(3'b011);
    sup_undervoltage_lockout <= 1'b0;
    wait_st(chg_pkg::ST_SHUTDOWN, 20);
    wait_stat(3'b111);
    {sup_undervoltage_lockout, bat_in} <= 2'b11;
    bus(1'b1, chg_pkg::REG_CTRL, 32'h0000_0010);
    wait_st(chg_pkg::ST_CC, 20);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(state === chg_pkg::ST_SHUTDOWN && pins === 3'b111, "reset");
    hresetn <= 1'b1;
    wait_stat(3'b011);
    $display("test supply and reset done");
  endtask

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    err_count = 0;
    comparisons = 0;
    hresetn = 1'b0;
    hsel = 1'b1;
    hsize = 3'b010;
    {htrans, hwrite, haddr, hwdata} = '0;
    {sup_undervoltage_lockout, sup_vreg, sup_bat, bat_in, bat_pre, t_lo_ok, t_hi_ok} = 7'h7f;
    {bat_vreg, bat_rech, term_low} = 3'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_charge();
    t_temp_timer();
    t_disable();
    t_test_mode();
    t_supply();
    wrap_up();
  end
endmodule

// [hdl/chg_dev.sv]
// chg_dev: charge cycle sequencer with status and power-good encoding
// analog comparator results arrive as asynchronous levels; all are synced
// Function
// [RQ1] suspend at once when temperature leaves window
// [RQ2] suspension stops pass transistor, freezes safety timer
// [RQ3] test mode: sense driven high, no battery
// [RQ4] test mode regulates, current capped by adapter set
// [RQ5] leave test mode on sense release, power cycle
// [RQ6] bias current off in shutdown, standby, test
// [RQ7] sense pull-down only in standby, test
// [RQ8] status outputs only drive low or release
// [RQ9] charging: a low; complete: b low
// [RQ10] shutdown, standby, faults, test output encoding
// [RQ11] usb select low picks low current limit
// [RQ12] power-good low when supply valid above battery
// [RQ13] pulse power-good while probing for battery
// [RQ14] power-good only sinks, never sources
// [RQ15] low timer enable runs safety timer
// [RQ16] floating or high adapter set disables device
// [RQ17] re-enable starts fresh charge cycle
// [RQ18] floating usb select also disables device
// [RQ19] host never leaves usb select floating; here control bit CTRL_USB_FLOAT floats it when software sets it
// [RQ20] timer expiry in fast charge latches fault
// [RQ21] termination comparator filtered over 1 ms
// [RQ22] complete state recharges below threshold
// [RQ23] inputs synchronised; reset forces shutdown
// [RQ24] status outputs registered, change on transitions
`timescale 1ns/100ps
module chg_dev #(
  parameter int unsigned SAFETY_CYC = chg_pkg::SAFETY_CYC,
  parameter int unsigned FILT_CYC   = chg_pkg::TERM_FILT_CYC
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  chg_if.dev        link,
  input  wire logic supply_above_undervoltage_lockout,
  input  wire logic supply_above_bat,
  input  wire logic supply_above_vreg_margin,
  input  wire logic battery_present,
  input  wire logic bat_below_precond,
  input  wire logic bat_at_vreg,
  input  wire logic bat_below_recharge,
  input  wire logic term_current_low,
  input  wire logic temp_above_low,
  input  wire logic temp_below_high,
  output logic      pass_on,
  output logic      ldo_mode,
  output logic      current_high,
  output logic      current_from_adapter,
  output logic      precond_current,
  output logic      thermistor_bias_current,
  output logic      sense_pulldown,
  output logic      low_power,
  output chg_pkg::chg_state_t state
);
  localparam int NS = 13;
  logic [NS-1:0] raw;
  logic [NS-1:0] sy1_r;
  logic [NS-1:0] sy2_r;
  assign raw = {supply_above_undervoltage_lockout, supply_above_bat,
                supply_above_vreg_margin, battery_present,
                bat_below_precond, bat_at_vreg, bat_below_recharge,
                term_current_low, temp_above_low, temp_below_high,
                link.adapter_current_set | link.adp_float,
                link.usb_current_select, link.usb_float};

  // two-flop synchronisers, one per input [RQ23]
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sy1_r[gi] <= 1'b0;
          sy2_r[gi] <= 1'b0;
        end else begin
          sy1_r[gi] <= raw[gi];
          sy2_r[gi] <= sy1_r[gi];
        end
      end
    end
  endgenerate

  logic s_undervoltage_lockout, s_abv_bat, s_vm, s_bat, s_pre, s_vreg, s_rech;
  logic s_term, s_tlo, s_thi, s_adp_off, s_usb_hi, s_usb_flt;
  assign {s_undervoltage_lockout, s_abv_bat, s_vm, s_bat, s_pre, s_vreg, s_rech,
          s_term, s_tlo, s_thi, s_adp_off, s_usb_hi, s_usb_flt} = sy2_r;

  logic te_s1_r, te_s2_r, tst_s1_r, tst_s2_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      te_s1_r  <= 1'b1;
      te_s2_r  <= 1'b1;
      tst_s1_r <= 1'b0;
      tst_s2_r <= 1'b0;
    end else begin
      te_s1_r  <= link.safety_timer_enable_n;
      te_s2_r  <= te_s1_r;
      tst_s1_r <= link.temp_sense_test;
      tst_s2_r <= tst_s1_r;
    end
  end

  logic power_ok, enabled, temp_ok, timer_run;
  assign power_ok = s_undervoltage_lockout & s_abv_bat;
  assign enabled  = ~s_adp_off & ~s_usb_flt; // [RQ16] [RQ18]
  assign temp_ok  = s_tlo & s_thi;           // [RQ1]
  assign timer_run = ~te_s2_r;               // [RQ15]

  chg_pkg::chg_state_t st_r, st_nxt;
  logic [31:0] tmr_r;
  logic [31:0] filt_r;
  logic        tmr_exp, filt_done;
  assign tmr_exp   = timer_run && (tmr_r >= SAFETY_CYC - 1);
  assign filt_done = (filt_r >= FILT_CYC - 1);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      chg_pkg::ST_SHUTDOWN:
        if (power_ok)
          st_nxt = chg_pkg::ST_STANDBY;
      chg_pkg::ST_STANDBY:
        if (tst_s2_r && !s_bat)
          st_nxt = chg_pkg::ST_TEST;                 // [RQ3]
        else if (enabled && s_bat)
          st_nxt = s_pre ? chg_pkg::ST_PRECOND      // [RQ17]
                         : chg_pkg::ST_CC;
      chg_pkg::ST_PRECOND, chg_pkg::ST_CC, chg_pkg::ST_CV: begin
        if (!temp_ok)
          st_nxt = chg_pkg::ST_TEMP_FLT;             // [RQ1]
        else if (tmr_exp)
          st_nxt = chg_pkg::ST_TMR_FLT;              // [RQ20]
        else if (st_r == chg_pkg::ST_PRECOND && !s_pre)
          st_nxt = chg_pkg::ST_CC;
        else if (st_r == chg_pkg::ST_CC && s_vreg)
          st_nxt = chg_pkg::ST_CV;
        else if (st_r == chg_pkg::ST_CV && s_term && filt_done)
          st_nxt = chg_pkg::ST_DONE;                 // [RQ21]
      end
      chg_pkg::ST_TEMP_FLT:
        if (temp_ok)
          st_nxt = chg_pkg::ST_CC;                   // [RQ2]
      chg_pkg::ST_DONE:
        if (s_rech)
          st_nxt = chg_pkg::ST_PRECOND;              // [RQ22]
      chg_pkg::ST_TMR_FLT:
        st_nxt = chg_pkg::ST_TMR_FLT;                // [RQ20]
      chg_pkg::ST_TEST:
        if (!tst_s2_r)
          st_nxt = chg_pkg::ST_STANDBY;              // [RQ5]
      default:
        st_nxt = chg_pkg::ST_SHUTDOWN;
    endcase
    // overrides: power loss, disable, battery removal
    if (!power_ok)
      st_nxt = chg_pkg::ST_SHUTDOWN;                 // [RQ5] [RQ23]
    // standby left out: a battery-less standby must still reach test mode
    else if (st_r != chg_pkg::ST_TEST && st_r != chg_pkg::ST_SHUTDOWN
             && st_r != chg_pkg::ST_STANDBY && (!enabled || !s_bat))
      st_nxt = chg_pkg::ST_STANDBY;                  // [RQ16] [RQ20]
  end

  logic [3:0] resume_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      st_r <= chg_pkg::ST_SHUTDOWN;                  // [RQ23]
    else if (st_r == chg_pkg::ST_TEMP_FLT && st_nxt == chg_pkg::ST_CC)
      st_r <= chg_chg_resume(resume_r);
    else
      st_r <= st_nxt;
  end

  function automatic chg_pkg::chg_state_t chg_chg_resume(
    input logic [3:0] code
  );
    chg_chg_resume = chg_pkg::chg_state_t'(code);
  endfunction

  // remember which charge phase a temperature suspension interrupted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      resume_r <= 4'h3;
    else if (st_r == chg_pkg::ST_PRECOND || st_r == chg_pkg::ST_CC
             || st_r == chg_pkg::ST_CV)
      resume_r <= st_r;
  end

  logic charging;
  assign charging = (st_r == chg_pkg::ST_PRECOND) ||
                    (st_r == chg_pkg::ST_CC) || (st_r == chg_pkg::ST_CV);

  // safety timer: frozen in suspension, cleared on entry to fast charge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tmr_r <= '0;
    else if (!charging && st_r != chg_pkg::ST_TEMP_FLT)
      tmr_r <= '0;
    else if (st_r == chg_pkg::ST_PRECOND && st_nxt == chg_pkg::ST_CC)
      tmr_r <= '0;
    else if (charging && timer_run)
      tmr_r <= tmr_r + 32'h0000_0001;                // [RQ2]
  end

  // termination qualifier; any gap in the comparator restarts it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      filt_r <= '0;
    else if (st_r == chg_pkg::ST_CV && s_term)
      filt_r <= filt_r + 32'h0000_0001;              // [RQ21]
    else
      filt_r <= '0;
  end

  // power-good probe pulse while supply sits below vreg margin
  logic [15:0] probe_r;
  logic        probe_ph_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      probe_r    <= '0;
      probe_ph_r <= 1'b0;
    end else if (probe_r == 16'(chg_pkg::PROBE_HALF_CYC - 1)) begin
      probe_r    <= '0;
      probe_ph_r <= ~probe_ph_r;
    end else begin
      probe_r    <= probe_r + 16'h0001;
    end
  end

  // registered open-drain encodings; data fixed low, only enables move
  logic a_low_r, b_low_r, pg_low_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_low_r  <= 1'b0;
      b_low_r  <= 1'b0;
      pg_low_r <= 1'b0;
    end else begin
      a_low_r  <= charging || st_r == chg_pkg::ST_TEST;     // [RQ9] [RQ10]
      b_low_r  <= st_r == chg_pkg::ST_DONE ||
                  st_r == chg_pkg::ST_TEST;                 // [RQ9] [RQ10]
      pg_low_r <= st_r != chg_pkg::ST_SHUTDOWN && power_ok  // [RQ12]
                  && (s_vm || probe_ph_r);                  // [RQ13]
    end
  end

  assign link.charge_status_a_o    = 1'b0;          // [RQ8]
  assign link.charge_status_b_o    = 1'b0;          // [RQ8]
  assign link.supply_valid_n_o     = 1'b0;          // [RQ14]
  assign link.charge_status_a_oe_n = ~a_low_r;      // [RQ24]
  assign link.charge_status_b_oe_n = ~b_low_r;      // [RQ24]
  assign link.supply_valid_n_oe_n  = ~pg_low_r;     // [RQ24]

  assign pass_on  = charging || st_r == chg_pkg::ST_TEST;   // [RQ2]
  assign ldo_mode = st_r == chg_pkg::ST_TEST;               // [RQ4]
  assign current_from_adapter = ldo_mode;                   // [RQ4]
  assign current_high    = s_usb_hi;                        // [RQ11]
  assign precond_current = st_r == chg_pkg::ST_PRECOND;
  assign thermistor_bias_current = !(st_r == chg_pkg::ST_SHUTDOWN ||
                                     st_r == chg_pkg::ST_STANDBY ||
                                     ldo_mode);             // [RQ6]
  assign sense_pulldown = st_r == chg_pkg::ST_STANDBY || ldo_mode; // [RQ7]
  assign low_power = !enabled;                              // [RQ16]
  assign state     = st_r;
endmodule

// [hdl/chg_host.sv]
// chg_host: host end driving the control pins, reporting over AHB-Lite
// assumes the device outputs are open-drain, resolved in the interface
`timescale 1ns/100ps
module chg_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  chg_if.host              link,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  logic [5:0] ctrl_r;
  logic       wr_pend_r;
  logic [7:0] addr_r;
  logic [2:0] s1_r, s2_r;

  // pins from the device are asynchronous to this clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= 3'b111;
      s2_r <= 3'b111;
    end else begin
      s1_r <= {link.pg_pin, link.stat_b_pin, link.stat_a_pin};
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      addr_r    <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ctrl_r <= chg_pkg::CTRL_RST;
    else if (wr_pend_r && addr_r == chg_pkg::REG_CTRL)
      ctrl_r <= hwdata[5:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
      case (haddr[7:0])
        chg_pkg::REG_CTRL: hrdata <= {26'h00_0000, ctrl_r};
        chg_pkg::REG_STAT: hrdata <= {29'h000_0000, s2_r};
        default:           hrdata <= 32'h0000_0000;
      endcase
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // the usb select is never floated unless software asks for it [RQ19]
  assign link.adapter_current_set      = ctrl_r[chg_pkg::CTRL_ADP];
  assign link.adapter_current_set_oe_n = ctrl_r[chg_pkg::CTRL_ADP_FLOAT];
  assign link.usb_current_select       = ctrl_r[chg_pkg::CTRL_USB_HI];
  assign link.usb_current_select_oe_n  = ctrl_r[chg_pkg::CTRL_USB_FLOAT];
  assign link.safety_timer_enable_n    = ctrl_r[chg_pkg::CTRL_TMR_DIS];
  assign link.temp_sense_test          = ctrl_r[chg_pkg::CTRL_TEST];
endmodule

// [hdl/chg_if.sv]
// chg_if: pin-level link between the charger control and its host
// open-drain pins resolve here from output enables (low enable = driving)
`timescale 1ns/100ps
interface chg_if;
  logic charge_status_a_o;
  logic charge_status_a_oe_n;
  logic charge_status_b_o;
  logic charge_status_b_oe_n;
  logic supply_valid_n_o;
  logic supply_valid_n_oe_n;
  logic usb_current_select;
  logic usb_current_select_oe_n;
  logic adapter_current_set;
  logic adapter_current_set_oe_n;
  logic safety_timer_enable_n;
  logic temp_sense_test;
  // resolved levels, released lines pulled up
  logic stat_a_pin;
  logic stat_b_pin;
  logic pg_pin;
  logic usb_float;
  logic adp_float;
  assign stat_a_pin = charge_status_a_oe_n ? 1'b1 : charge_status_a_o;
  assign stat_b_pin = charge_status_b_oe_n ? 1'b1 : charge_status_b_o;
  assign pg_pin     = supply_valid_n_oe_n ? 1'b1 : supply_valid_n_o;
  assign usb_float  = usb_current_select_oe_n;
  assign adp_float  = adapter_current_set_oe_n;

  modport dev (
    output charge_status_a_o, charge_status_a_oe_n,
    output charge_status_b_o, charge_status_b_oe_n,
    output supply_valid_n_o, supply_valid_n_oe_n,
    input  usb_current_select, usb_float,
    input  adapter_current_set, adp_float,
    input  safety_timer_enable_n, temp_sense_test
  );
  modport host (
    input  stat_a_pin, stat_b_pin, pg_pin,
    output usb_current_select, usb_current_select_oe_n,
    output adapter_current_set, adapter_current_set_oe_n,
    output safety_timer_enable_n, temp_sense_test
  );
endinterface

// [hdl/chg_pkg.sv]
// chg_pkg: shared constants and types for the charger control and its host
// assumes a 100 MHz control clock on both ends
package chg_pkg;
  localparam int unsigned CLK_MHZ         = 100;
  // termination filter time in microseconds
  localparam int unsigned TERM_FILT_US    = 1000;
  localparam int unsigned TERM_FILT_CYC   = TERM_FILT_US * CLK_MHZ;
  // safety timer default, cycles (4.5 s at 100 MHz); shortened by parameter in simulation
  localparam int unsigned SAFETY_CYC      = 32'h1AD2_7480;
  // power-good probe pulse half period, cycles
  localparam int unsigned PROBE_HALF_CYC  = 32'h0000_0400;
  // host register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL         = 8'h00;
  localparam logic [7:0] REG_STAT         = 8'h04;
  // control field positions
  localparam int unsigned CTRL_ADP        = 0;
  localparam int unsigned CTRL_ADP_FLOAT  = 1;
  localparam int unsigned CTRL_USB_HI     = 2;
  localparam int unsigned CTRL_USB_FLOAT  = 3;
  localparam int unsigned CTRL_TMR_DIS    = 4;
  localparam int unsigned CTRL_TEST       = 5;
  localparam logic [5:0]  CTRL_RST        = 6'h01;

  typedef enum logic [3:0] {
    ST_SHUTDOWN = 4'b0000,
    ST_STANDBY  = 4'b0001,
    ST_PRECOND  = 4'b0010,
    ST_CC       = 4'b0011,
    ST_CV       = 4'b0100,
    ST_DONE     = 4'b0101,
    ST_TEMP_FLT = 4'b0110,
    ST_TMR_FLT  = 4'b0111,
    ST_TEST     = 4'b1000
  } chg_state_t;
endpackage
